/* nrd_pkg.sv */
// nrd_pkg: shared types and constants for the table-lookup / prescaler / serial read unit
// assumes the core hands over the raw 10-bit instruction word per cycle; the read unit decodes the opcodes itself
package nrd_pkg;

  localparam int unsigned NRD_INSN_W    = 10;
  localparam int unsigned NRD_PAGE_W    = 6;
  localparam int unsigned NRD_BANK_W    = 1;
  localparam int unsigned NRD_PCH_W     = 7;
  localparam int unsigned NRD_PCL_W     = 7;
  localparam int unsigned NRD_SP_W      = 3;
  localparam int unsigned NRD_BYTE_W    = 8;
  localparam int unsigned NRD_NIB_W     = 4;
  localparam int unsigned NRD_ROMDAT_W  = 10;

  // opcode encodings
  localparam logic [9:0] NRD_OP_LOOKUP_MASK = 10'h3c0;
  localparam logic [9:0] NRD_OP_LOOKUP_VAL  = 10'h080;
  localparam logic [9:0] NRD_OP_READ_PRESC  = 10'h275;
  localparam logic [9:0] NRD_OP_READ_SERIAL = 10'h278;

  localparam logic [NRD_SP_W-1:0]   NRD_SP_RST   = 3'h7;
  localparam logic [NRD_BANK_W-1:0] NRD_BANK_RST = 1'h0;
  localparam logic [NRD_SP_W-1:0]   NRD_SP_ONE   = 3'h1;

  typedef enum logic [1:0] {
    NRD_IDLE   = 2'b00,
    NRD_PUSH   = 2'b01,
    NRD_READ   = 2'b10,
    NRD_RESTORE= 2'b11
  } nrd_state_t;

  typedef struct packed {
    logic [NRD_PCH_W-1:0] page;
    logic [NRD_PCL_W-1:0] low;
  } nrd_pc_t;

  typedef struct packed {
    logic [NRD_NIB_W-1:0] b;
    logic [NRD_NIB_W-1:0] a;
    logic                 we;
  } nrd_ab_t;

  typedef struct packed {
    logic [NRD_SP_W-1:0] sp;
    logic                push;
    nrd_pc_t             push_pc;
    logic                pc_we;
    nrd_pc_t             pc;
  } nrd_stk_t;

endpackage

/* nrd_read_unit.sv */
// nrd_read_unit: executes rom_table_lookup, read_prescaler_to_ab, read_serial_shift_to_ab
// assumes one clk edge per instruction cycle; rom answers combinationally; inputs are core-local
`timescale 1ns/1ps

module nrd_read_unit
  import nrd_pkg::*;
(
  input  wire logic                    clk,
  input  wire logic                    sys_rst,
  input  wire logic                    insn_valid,
  input  wire logic [NRD_INSN_W-1:0]   insn,
  input  wire logic                    set_rom_bank,
  input  wire logic                    reset_rom_bank,
  input  wire nrd_pc_t                 pc_in,
  input  wire logic [NRD_SP_W-1:0]     stack_pointer,
  input  wire nrd_pc_t                 return_stack_top,
  input  wire logic [NRD_NIB_W-1:0]    acc_in,
  input  wire logic [2:0]              index_register_d,
  input  wire logic [NRD_BYTE_W-1:0]   timer_prescaler,
  input  wire logic [NRD_BYTE_W-1:0]   serial_shift,
  input  wire logic [NRD_ROMDAT_W-1:0] rom_data,
  output logic                         busy,
  output nrd_pc_t                      rom_addr,
  output nrd_ab_t                      ab_out,
  output nrd_stk_t                     stk_out,
  output logic                         carry_we,
  output logic                         skip_next
);

  ////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    nrd_state_t             st;
    logic [NRD_BANK_W-1:0]  bank;
    nrd_pc_t                addr;
    nrd_pc_t                saved_pc;
    nrd_ab_t                ab;
    nrd_stk_t               stk;
    logic                   busy;
  } nrd_core_t;

  nrd_core_t state_r;
  nrd_core_t state_nxt;

  logic is_lookup;
  logic is_presc;
  logic is_serial;

  assign is_lookup = insn_valid && ((insn & NRD_OP_LOOKUP_MASK) == NRD_OP_LOOKUP_VAL);
  assign is_presc  = insn_valid && (insn == NRD_OP_READ_PRESC);
  assign is_serial = insn_valid && (insn == NRD_OP_READ_SERIAL);

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    state_nxt          = state_r;
    state_nxt.ab.we    = 1'b0;
    state_nxt.stk.push = 1'b0;
    state_nxt.stk.pc_we= 1'b0;
    if (set_rom_bank) begin
      state_nxt.bank = 1'h1;
    end else if (reset_rom_bank) begin
      state_nxt.bank = NRD_BANK_RST;
    end
    case (state_r.st)
      NRD_IDLE: begin
        state_nxt.busy = 1'b0;
        if (is_lookup) begin
          state_nxt.stk.sp      = stack_pointer + NRD_SP_ONE;
          state_nxt.stk.push    = 1'b1;
          state_nxt.stk.push_pc = pc_in;
          state_nxt.saved_pc    = pc_in;
          state_nxt.addr.page   = {state_r.bank, insn[NRD_PAGE_W-1:0]};
          state_nxt.addr.low    = {index_register_d, acc_in};
          state_nxt.busy        = 1'b1;
          state_nxt.st          = NRD_PUSH;
        end else if (is_presc) begin
          state_nxt.ab = '{b: timer_prescaler[7:4], a: timer_prescaler[3:0], we: 1'b1};
        end else if (is_serial) begin
          state_nxt.ab = '{b: serial_shift[7:4], a: serial_shift[3:0], we: 1'b1};
        end
      end
      NRD_PUSH: begin
        // address already on rom_addr; data sampled next
        state_nxt.st = NRD_READ;
      end
      NRD_READ: begin
        state_nxt.ab = '{b: rom_data[7:4], a: rom_data[3:0], we: 1'b1};
        state_nxt.stk.pc    = return_stack_top;
        state_nxt.stk.pc_we = 1'b1;
        state_nxt.stk.sp    = state_r.stk.sp - NRD_SP_ONE;
        state_nxt.busy      = 1'b0;
        state_nxt.st        = NRD_IDLE;
      end
      default: begin
        state_nxt.st   = NRD_IDLE;
        state_nxt.busy = 1'b0;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_r          <= '0;
      state_r.st       <= NRD_IDLE;
      state_r.bank     <= NRD_BANK_RST;
      state_r.stk.sp   <= NRD_SP_RST;
    end else begin
      state_r <= state_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // carry and skip never asserted by these instructions
  logic carry_we_r;
  logic skip_next_r;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      carry_we_r  <= 1'b0;
      skip_next_r <= 1'b0;
    end else begin
      carry_we_r  <= 1'b0;
      skip_next_r <= 1'b0;
    end
  end

  assign busy      = state_r.busy;
  assign rom_addr  = state_r.addr;
  assign ab_out    = state_r.ab;
  assign stk_out   = state_r.stk;
  assign carry_we  = carry_we_r;
  assign skip_next = skip_next_r;

endmodule

/* nrd_sva.sv */
// read unit port checks
// bound to nrd_read_unit; bank pulses kept apart from lookup takes
`timescale 1ns/1ps
module nrd_sva
  import nrd_pkg::*;
(
  input wire logic clk, sys_rst, insn_valid, set_rom_bank, reset_rom_bank, busy, carry_we, skip_next,
  input wire logic [9:0] insn, rom_data,
  input wire nrd_pc_t pc_in, return_stack_top, rom_addr,
  input wire logic [2:0] stack_pointer, index_register_d,
  input wire logic [3:0] acc_in,
  input wire logic [7:0] timer_prescaler, serial_shift,
  input wire nrd_ab_t ab_out,
  input wire nrd_stk_t stk_out
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  logic bank_r;
  wire rd = insn_valid && !busy;
  wire lk = rd && (insn & NRD_OP_LOOKUP_MASK) == NRD_OP_LOOKUP_VAL;
  always_ff @(posedge clk) bank_r <= sys_rst ? 1'b0 : set_rom_bank ? 1'b1 : reset_rom_bank ? 1'b0 : bank_r;
  sequence s_fill; busy [*2] ##1 !busy; endsequence
  chk_lookup_addr: assert property (lk |=> rom_addr.low == {$past(index_register_d), $past(acc_in)}
    && rom_addr.page[5:0] == $past(insn[5:0])) else $error("bad lookup address");
  chk_lookup_data: assert property (lk |-> ##3 ab_out == {$past(rom_data[7:0]), 1'b1}) else $error("bad lookup data");
  chk_stack_push: assert property (lk |=> stk_out.push && stk_out.sp == $past(stack_pointer) + 3'h1
    && stk_out.push_pc == $past(pc_in)) else $error("bad push");
  chk_stack_restore: assert property (lk |-> ##3 stk_out.pc_we && stk_out.pc == $past(return_stack_top)
    && stk_out.sp == $past(stack_pointer, 3)) else $error("bad restore");
  chk_bank_page: assert property (lk && !set_rom_bank && !reset_rom_bank |=> rom_addr.page[6] == $past(bank_r))
    else $error("bad bank");
  chk_presc_read: assert property (rd && insn == NRD_OP_READ_PRESC |=> ab_out == {$past(timer_prescaler), 1'b1})
    else $error("bad prescaler read");
  chk_serial_read: assert property (rd && insn == NRD_OP_READ_SERIAL |=> ab_out == {$past(serial_shift), 1'b1})
    else $error("bad serial read");
  chk_lookup_cycles: assert property (lk |=> s_fill) else $error("bad lookup length");
  chk_no_flags: assert property (!carry_we && !skip_next) else $error("flag touched");
endmodule
bind nrd_read_unit nrd_sva u_chk (.clk(clk), .sys_rst(sys_rst), .insn_valid(insn_valid), .insn(insn),
  .set_rom_bank(set_rom_bank), .reset_rom_bank(reset_rom_bank), .pc_in(pc_in), .stack_pointer(stack_pointer),
  .return_stack_top(return_stack_top), .acc_in(acc_in), .index_register_d(index_register_d),
  .timer_prescaler(timer_prescaler), .serial_shift(serial_shift), .rom_data(rom_data), .busy(busy),
  .rom_addr(rom_addr), .ab_out(ab_out), .stk_out(stk_out), .carry_we(carry_we), .skip_next(skip_next));

/* tb.sv */
// random and corner runs of the three read instructions
// assumes rom and stack answer immediately; sp kept clear of overflow
`timescale 1ns/1ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin num_errors++; $display("unexpected %0t %h %h", $time, g, e); end end
module tb;
  import nrd_pkg::*;
  logic clk = 0, sys_rst = 1, insn_valid = 0, set_rom_bank = 0, reset_rom_bank = 0, bank_e = 0;
  logic busy, carry_we, skip_next;
  logic [9:0] insn = '0, rom_data = '0;
  logic [2:0] stack_pointer = '0, index_register_d = '0;
  logic [3:0] acc_in = '0;
  logic [7:0] timer_prescaler = '0, serial_shift = '0;
  logic [15:0] lf = 16'h0002;
  nrd_pc_t pc_in = '0, return_stack_top = '0, rom_addr;
  nrd_ab_t ab_out;
  nrd_stk_t stk_out;
  int num_errors = 0, samples_checked = 0, cyc = 0;
  nrd_read_unit u_nrd_read_unit (.clk(clk), .sys_rst(sys_rst), .insn_valid(insn_valid), .insn(insn),
    .set_rom_bank(set_rom_bank), .reset_rom_bank(reset_rom_bank), .pc_in(pc_in), .stack_pointer(stack_pointer),
    .return_stack_top(return_stack_top), .acc_in(acc_in), .index_register_d(index_register_d),
    .timer_prescaler(timer_prescaler), .serial_shift(serial_shift), .rom_data(rom_data), .busy(busy),
    .rom_addr(rom_addr), .ab_out(ab_out), .stk_out(stk_out), .carry_we(carry_we), .skip_next(skip_next));
  initial forever #2.5 clk = ~clk;
  task rnd;
    lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
    {pc_in, index_register_d, acc_in} = {lf, ~lf[4:0]};
    {return_stack_top, rom_data} = {~lf, lf[7:0]};
    {timer_prescaler, serial_shift} = {lf[11:4], ~lf[7:0]};
    stack_pointer = lf[2:0] & 3'h5;
  endtask
  // one instruction; lookups hold their sources for all three cycles
  task run(input logic [9:0] code);
    rnd();
    insn = code;
    insn_valid = 1;
    @(posedge clk);
    #1;
    `CHK({carry_we, skip_next}, 2'h0)
    if (code == NRD_OP_READ_PRESC) `CHK(ab_out, {timer_prescaler, 1'b1})
    else if (code == NRD_OP_READ_SERIAL) `CHK(ab_out, {serial_shift, 1'b1})
    else begin
      `CHK(rom_addr, {bank_e, code[5:0], index_register_d, acc_in})
      `CHK({busy, stk_out.push, stk_out.sp, stk_out.push_pc}, {2'h3, stack_pointer + 3'h1, pc_in})
      repeat (2) @(posedge clk);
      #1;
      `CHK(ab_out, {rom_data[7:0], 1'b1})
      `CHK({busy, stk_out.pc_we, stk_out.sp, stk_out.pc}, {2'h1, stack_pointer, return_stack_top})
    end
  endtask
  task final_report;
    $display("errors %0d checked %0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  always @(posedge clk) if (++cyc == 2000) begin num_errors++; final_report(); end
  initial begin
    repeat (5) @(posedge clk);
    #1;
    sys_rst = 0;
    run(NRD_OP_LOOKUP_VAL | 10'h03f);
    for (int i = 0; i < 80; i++) begin
      rnd();
      case (lf[1:0])
        2'h0: run(NRD_OP_READ_PRESC);
        2'h1: run(NRD_OP_READ_SERIAL);
        2'h2: run(NRD_OP_LOOKUP_VAL | {4'h0, lf[7:2]});
        default: begin
          insn_valid = 0;
          {bank_e, set_rom_bank, reset_rom_bank} = {lf[4], lf[4], ~lf[4]};
          @(posedge clk);
          #1;
          {set_rom_bank, reset_rom_bank} = 2'h0;
          @(posedge clk);
          #1;
        end
      endcase
    end
    final_report();
  end
endmodule
